// ### pfswp_ctrl.sv
`timescale 1ns/10ps
// Summary of operation
// - Either physical block maps to address zero
// - Boot fetches SP at 0, PC at 4
// - No swap before initialisation
// - Block at zero is active, other nonactive
// - Completed swap exchanges active and nonactive
// - Each reset sequence fetches from mapped block zero
// - Active-block flag set during reset sequence
// - Read-only flag shows swap initialised
// - Execute one block while other is written
// - Swap exchanges block base addresses
// - Swap requested like other flash commands
// - Four options: init, update, complete, report
// - Reset after complete swaps, enters ready
// - Indicator sector erase moves update to erased
// - Out-of-sequence option raises error
module pfswp_ctrl #(
	parameter int ADDR_W = 20
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Persistent swap record, as held in the indicators
	input wire logic NV_INIT,
	input wire logic NV_COMPLETE,
	input wire logic NV_BLOCK,
	// Reset sequence start, one-cycle pulse
	input wire logic RESET_SEQ,
	// Swap command, issued like other flash commands
	input wire logic CMD_VALID,
	input wire logic [1:0] CMD_OPT,
	// Nonactive block indicator sector erased
	input wire logic IND_ERASED,
	// Nonactive block program or erase in progress
	input wire logic NV_BUSY,
	// Processor logical address
	input wire logic [ADDR_W-1:0] CPU_ADDR,
	// Physical mapping out
	output logic [ADDR_W-1:0] PHYS_ADDR,
	output logic PHYS_BLOCK,
	output logic CPU_STALL,
	// Boot vector fetch
	output logic [31:0] BOOT_ADDR,
	output logic BOOT_FETCH,
	output logic BOOT_DONE,
	// Status
	output logic ACTIVE_BLOCK,
	output logic SWAP_INITIALISED_FLAG,
	output logic [4:0] SWAP_STATE,
	output logic NEXT_BLOCK,
	output logic CMD_DONE,
	output logic CMD_ERROR,
	// Persistent record updates
	output logic NV_WR,
	output logic NV_WR_INIT,
	output logic NV_WR_COMPLETE,
	output logic NV_WR_BLOCK
);
	// One address bit picks the block, the rest must still span a block
	if (ADDR_W < 4 || ADDR_W > 32) begin : g_width_check
		$error("ADDR_W out of range");
	end

	// Swap state
	pfswp_pkg::pfswp_state_t state_q;
	pfswp_pkg::pfswp_state_t state_d;
	logic is_init_q;
	logic is_init_d;
	logic next_q;
	logic next_d;
	// Block mapping
	logic active_q;
	logic active_d;
	logic [ADDR_W-1:0] phys_q;
	logic [ADDR_W-1:0] phys_d;
	logic phys_blk_q;
	logic phys_blk_d;
	logic stall_q;
	logic stall_d;
	// Boot vector fetch
	logic [1:0] boot_q;
	logic [1:0] boot_d;
	logic [31:0] boot_addr_q;
	logic [31:0] boot_addr_d;
	logic fetch_q;
	logic fetch_d;
	logic done_q;
	logic done_d;
	// Command answer and record writes
	logic cmd_done_q;
	logic cmd_done_d;
	logic err_q;
	logic err_d;
	logic nv_wr_q;
	logic nv_wr_d;
	logic nv_init_q;
	logic nv_init_d;
	logic nv_cmp_q;
	logic nv_cmp_d;
	logic nv_blk_q;
	logic nv_blk_d;

	// Record decoding at reset sequence
	wire swap_pending = NV_INIT & NV_COMPLETE;
	wire boot_block = swap_pending ? ~NV_BLOCK : NV_BLOCK;
	wire is_init = state_q != pfswp_pkg::ST_UNINIT;
	wire is_report = CMD_OPT == pfswp_pkg::OPT_REPORT;
	wire opt_init = CMD_OPT == pfswp_pkg::OPT_SET_INDICATOR;
	wire opt_upd = CMD_OPT == pfswp_pkg::OPT_UPDATE;
	wire opt_cmp = CMD_OPT == pfswp_pkg::OPT_COMPLETE;
	wire ok_init = opt_init & ~is_init;
	wire ok_upd = opt_upd & (state_q == pfswp_pkg::ST_READY);
	wire ok_cmp = opt_cmp & (state_q == pfswp_pkg::ST_UPD_ERASED);
	wire cmd_ok = is_report | ok_init | ok_upd | ok_cmp;
	wire booting = boot_q != pfswp_pkg::BOOT_STEP_RUN;
	// Top address bit picks the block, lower bits pass through
	wire [ADDR_W-1:0] addr_lo = {1'b0, CPU_ADDR[ADDR_W-2:0]};
	wire sel_upper = CPU_ADDR[ADDR_W-1];
	wire map_block = sel_upper ^ active_q;
	// Only the nonactive block may be busy; active reads keep running
	wire stall = NV_BUSY & (map_block != active_q);

	// Next values of the registers
	assign active_d = RESET_SEQ ? boot_block : active_q;
	assign is_init_d = state_d != pfswp_pkg::ST_UNINIT;
	assign next_d = (state_d == pfswp_pkg::ST_COMPLETE) ? ~active_q : active_q;
	assign phys_d = addr_lo | {map_block, {(ADDR_W-1){1'b0}}};
	assign phys_blk_d = map_block;
	// Boot stalls every access until both vectors are fetched
	assign stall_d = stall | booting;
	assign fetch_d = (boot_q == pfswp_pkg::BOOT_STEP_SP) | (boot_q == pfswp_pkg::BOOT_STEP_PC);
	assign boot_addr_d = (boot_q == pfswp_pkg::BOOT_STEP_PC) ? pfswp_pkg::ADDR_PROG_CNT
		: pfswp_pkg::ADDR_STACK_PTR;
	assign done_d = boot_q == pfswp_pkg::BOOT_STEP_RUN;
	assign cmd_done_d = CMD_VALID;
	assign err_d = CMD_VALID & ~cmd_ok;
	assign nv_wr_d = CMD_VALID & (ok_init | ok_upd | ok_cmp);
	assign nv_init_d = 1'b1;
	// Record holds the block now at zero; a pending swap inverts it at reset
	assign nv_cmp_d = ok_cmp;
	assign nv_blk_d = active_q;

	always_comb begin
		state_d = state_q;
		case (state_q)
			pfswp_pkg::ST_UNINIT: begin
				if (CMD_VALID && ok_init) begin
					state_d = pfswp_pkg::ST_UPD_ERASED;
				end
			end
			pfswp_pkg::ST_READY: begin
				if (CMD_VALID && ok_upd) begin
					state_d = pfswp_pkg::ST_UPDATE;
				end
			end
			pfswp_pkg::ST_UPDATE: begin
				if (IND_ERASED) begin
					state_d = pfswp_pkg::ST_UPD_ERASED;
				end
			end
			pfswp_pkg::ST_UPD_ERASED: begin
				if (CMD_VALID && ok_cmp) begin
					state_d = pfswp_pkg::ST_COMPLETE;
				end
			end
			pfswp_pkg::ST_COMPLETE: begin
				state_d = pfswp_pkg::ST_COMPLETE;
			end
			default: begin
				state_d = pfswp_pkg::ST_UNINIT;
			end
		endcase
		if (RESET_SEQ) begin
			if (!NV_INIT) begin
				state_d = pfswp_pkg::ST_UNINIT;
			end else if (NV_COMPLETE) begin
				state_d = pfswp_pkg::ST_READY;
			end else begin
				state_d = pfswp_pkg::ST_READY;
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= pfswp_pkg::ST_UNINIT;
		end else begin
			state_q <= state_d;
		end
	end

	// Active block only moves in the reset sequence, or to RST_ACTIVE_BLOCK on RST_N
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			active_q <= pfswp_pkg::RST_ACTIVE_BLOCK;
		end else begin
			active_q <= active_d;
		end
	end

	// Boot vector fetch after each reset sequence
	always_comb begin
		boot_d = boot_q;
		case (boot_q)
			pfswp_pkg::BOOT_STEP_SP: begin
				boot_d = pfswp_pkg::BOOT_STEP_PC;
			end
			pfswp_pkg::BOOT_STEP_PC: begin
				boot_d = pfswp_pkg::BOOT_STEP_RUN;
			end
			default: begin
				boot_d = boot_q;
			end
		endcase
		if (RESET_SEQ) begin
			boot_d = pfswp_pkg::BOOT_STEP_SP;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			boot_q <= pfswp_pkg::RST_BOOT_STEP;
		end else begin
			boot_q <= boot_d;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			boot_addr_q <= pfswp_pkg::ADDR_STACK_PTR;
			fetch_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			fetch_q <= fetch_d;
			boot_addr_q <= boot_addr_d;
			done_q <= done_d;
		end
	end

	// Address translation
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			phys_q <= '0;
			phys_blk_q <= 1'b0;
		end else begin
			phys_q <= phys_d;
			phys_blk_q <= phys_blk_d;
		end
	end

	// Stall request
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			stall_q <= 1'b0;
		end else begin
			stall_q <= stall_d;
		end
	end

	// Command answer
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cmd_done_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			cmd_done_q <= cmd_done_d;
			err_q <= err_d;
		end
	end

	// Indicator record writes
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			nv_wr_q <= 1'b0;
			nv_init_q <= 1'b0;
			nv_cmp_q <= 1'b0;
			nv_blk_q <= 1'b0;
		end else begin
			nv_wr_q <= nv_wr_d;
			nv_init_q <= nv_init_d;
			nv_cmp_q <= nv_cmp_d;
			nv_blk_q <= nv_blk_d;
		end
	end

	assign PHYS_ADDR = phys_q;
	assign PHYS_BLOCK = phys_blk_q;
	assign CPU_STALL = stall_q;
	assign BOOT_ADDR = boot_addr_q;
	assign BOOT_FETCH = fetch_q;
	assign BOOT_DONE = done_q;
	assign ACTIVE_BLOCK = active_q;
	assign SWAP_INITIALISED_FLAG = is_init_q;
	assign SWAP_STATE = state_q;
	assign NEXT_BLOCK = next_q;
	assign CMD_DONE = cmd_done_q;
	assign CMD_ERROR = err_q;
	assign NV_WR = nv_wr_q;
	assign NV_WR_INIT = nv_init_q;
	assign NV_WR_COMPLETE = nv_cmp_q;
	assign NV_WR_BLOCK = nv_blk_q;

	// Status flags
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			is_init_q <= 1'b0;
			next_q <= pfswp_pkg::RST_ACTIVE_BLOCK;
		end else begin
			is_init_q <= is_init_d;
			next_q <= next_d;
		end
	end
endmodule

// ### pfswp_pkg.sv
package pfswp_pkg;
	// Swap states, one-hot
	typedef enum logic [4:0] {
		ST_UNINIT = 5'b0_0001,
		ST_READY = 5'b0_0010,
		ST_UPDATE = 5'b0_0100,
		ST_UPD_ERASED = 5'b0_1000,
		ST_COMPLETE = 5'b1_0000
	} pfswp_state_t;

	// Swap command options
	localparam logic [1:0] OPT_SET_INDICATOR = 2'h0;
	localparam logic [1:0] OPT_UPDATE = 2'h1;
	localparam logic [1:0] OPT_COMPLETE = 2'h2;
	localparam logic [1:0] OPT_REPORT = 2'h3;

	// Vector locations in the active block
	localparam logic [31:0] ADDR_STACK_PTR = 32'h0000_0000;
	localparam logic [31:0] ADDR_PROG_CNT = 32'h0000_0004;

	// Values after reset, and the boot sequence steps
	localparam logic RST_ACTIVE_BLOCK = 1'b0;
	localparam logic [1:0] RST_BOOT_STEP = 2'h0;
	localparam logic [1:0] BOOT_STEP_SP = 2'h1;
	localparam logic [1:0] BOOT_STEP_PC = 2'h2;
	localparam logic [1:0] BOOT_STEP_RUN = 2'h3;
endpackage

// ### pfswp_ctrl_asserts.sv
`timescale 1ns/10ps
module pfswp_chk #(parameter int ADDR_W = 20) (
	// Clock, reset
	input wire logic CLK,
	input wire logic RST_N,
	// Inputs
	input wire logic RESET_SEQ,
	input wire logic CMD_VALID,
	input wire logic [1:0] CMD_OPT,
	input wire logic IND_ERASED,
	input wire logic NV_BUSY,
	input wire logic [ADDR_W-1:0] CPU_ADDR,
	// Outputs
	input wire logic [ADDR_W-1:0] PHYS_ADDR,
	input wire logic [31:0] BOOT_ADDR,
	input wire logic BOOT_FETCH,
	input wire logic BOOT_DONE,
	input wire logic ACTIVE_BLOCK,
	input wire logic [4:0] SWAP_STATE,
	input wire logic CMD_DONE,
	input wire logic CMD_ERROR,
	input wire logic CPU_STALL
);
	logic [ADDR_W-1:0] want;
	assign want = {CPU_ADDR[ADDR_W-1] ^ ACTIVE_BLOCK, CPU_ADDR[ADDR_W-2:0]};
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	sequence s_vec;
		BOOT_FETCH && BOOT_ADDR == 32'h0000_0000 ##1 BOOT_FETCH && BOOT_ADDR == 32'h0000_0004;
	endsequence
	sequence s_boot;
		s_vec ##1 BOOT_DONE;
	endsequence
	chk_boot_vector_order: assert property (RESET_SEQ |-> ##2 s_boot)
		else $error("boot vectors out of order");
	chk_cmd_answer: assert property (CMD_VALID |=> CMD_DONE)
		else $error("command not answered");
	chk_report_clean: assert property (CMD_VALID && CMD_OPT == 2'h3 |=> !CMD_ERROR)
		else $error("report refused");
	chk_update_refused: assert property (CMD_VALID && CMD_OPT == 2'h1 && SWAP_STATE != 5'h02
		|=> CMD_ERROR && $stable(SWAP_STATE)) else $error("update accepted out of order");
	chk_complete_taken: assert property (CMD_VALID && CMD_OPT == 2'h2 && SWAP_STATE == 5'h08
		|=> SWAP_STATE == 5'h10) else $error("complete not taken");
	chk_erase_advance: assert property (SWAP_STATE == 5'h04 && IND_ERASED |=> SWAP_STATE == 5'h08)
		else $error("erase did not advance");
	chk_map_fixed: assert property ($changed(ACTIVE_BLOCK) |-> $past(RESET_SEQ))
		else $error("mapping moved outside reset sequence");
	chk_addr_map: assert property ($past(RST_N) |-> PHYS_ADDR == $past(want))
		else $error("address map wrong");
	chk_busy_stall: assert property (NV_BUSY && CPU_ADDR[ADDR_W-1] |=> CPU_STALL)
		else $error("busy block access not stalled");
	chk_active_runs: assert property (BOOT_DONE && !$past(RESET_SEQ) && !CPU_ADDR[ADDR_W-1] |=> !CPU_STALL)
		else $error("active block access stalled");
endmodule
bind pfswp_ctrl pfswp_chk #(.ADDR_W(ADDR_W)) i_chk (.CLK, .RST_N, .RESET_SEQ, .CMD_VALID, .CMD_OPT, .IND_ERASED,
	.CPU_ADDR, .PHYS_ADDR, .BOOT_ADDR, .BOOT_FETCH, .BOOT_DONE, .ACTIVE_BLOCK, .SWAP_STATE, .CMD_DONE, .CMD_ERROR,
	.NV_BUSY, .CPU_STALL);

// ### pfswp_nvrec.sv
`timescale 1ns/10ps
module pfswp_nvrec (
	// Clock
	input wire logic CLK,
	// Record writes
	input wire logic NV_WR,
	input wire logic NV_WR_INIT,
	input wire logic NV_WR_COMPLETE,
	input wire logic NV_WR_BLOCK,
	// Stored record
	output logic NV_INIT,
	output logic NV_COMPLETE,
	output logic NV_BLOCK
);
	// No reset: survives resets like the indicators
	initial {NV_INIT, NV_COMPLETE, NV_BLOCK} = 3'h0;
	always @(posedge CLK) begin
		if (NV_WR) begin
			{NV_INIT, NV_COMPLETE, NV_BLOCK} <= {NV_WR_INIT, NV_WR_COMPLETE, NV_WR_BLOCK};
		end
	end
endmodule

// ### program_flash_block_swap_tb.sv
`timescale 1ns/10ps
module program_flash_block_swap_tb;
	logic CLK = 1'b0, RST_N = 1'b0, RESET_SEQ = 1'b0, CMD_VALID = 1'b0, IND_ERASED = 1'b0, NV_BUSY = 1'b0;
	logic [1:0] CMD_OPT = 2'h0;
	logic [19:0] CPU_ADDR = 20'h0_0000;
	logic [15:0] lfsr = 16'h0008;
	logic NV_INIT, NV_COMPLETE, NV_BLOCK, NV_WR, NV_WR_INIT, NV_WR_COMPLETE, NV_WR_BLOCK;
	logic BOOT_DONE, ACTIVE_BLOCK, SWAP_INITIALISED_FLAG, CMD_ERROR, PHYS_BLOCK, NEXT_BLOCK;
	logic [4:0] SWAP_STATE;
	int bad_count = 0, n_checks = 0, cycles = 0;
	always #25 CLK = ~CLK;
	pfswp_ctrl #(.ADDR_W(20)) i_dut (.CLK, .RST_N, .NV_INIT, .NV_COMPLETE, .NV_BLOCK, .RESET_SEQ, .CMD_VALID,
		.CMD_OPT, .IND_ERASED, .NV_BUSY, .CPU_ADDR, .PHYS_ADDR(), .PHYS_BLOCK, .CPU_STALL(), .BOOT_ADDR(),
		.BOOT_FETCH(), .BOOT_DONE, .ACTIVE_BLOCK, .SWAP_INITIALISED_FLAG, .SWAP_STATE, .NEXT_BLOCK,
		.CMD_DONE(), .CMD_ERROR, .NV_WR, .NV_WR_INIT, .NV_WR_COMPLETE, .NV_WR_BLOCK);
	pfswp_nvrec i_rec (.CLK, .NV_WR, .NV_WR_INIT, .NV_WR_COMPLETE, .NV_WR_BLOCK, .NV_INIT, .NV_COMPLETE, .NV_BLOCK);
	function automatic logic [15:0] lfsr_next(logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic logic [4:0] next_state(logic [1:0] opt, logic [4:0] st);
		if (opt == 2'h0 && st == 5'h01) return 5'h08;
		if (opt == 2'h1 && st == 5'h02) return 5'h04;
		if (opt == 2'h2 && st == 5'h08) return 5'h10;
		return st;
	endfunction
	always @(negedge CLK) begin
		lfsr <= lfsr_next(lfsr);
		CPU_ADDR <= {lfsr[3:0], lfsr};
		NV_BUSY <= lfsr[5];
	end
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmd(logic [1:0] opt);
		logic [4:0] st;
		st = SWAP_STATE;
		CMD_VALID = 1'b1;
		CMD_OPT = opt;
		@(negedge CLK);
		CMD_VALID = 1'b0;
		chk(CMD_ERROR, opt != 2'h3 && next_state(opt, st) === st);
		chk(SWAP_STATE, next_state(opt, st));
		chk(NEXT_BLOCK, ACTIVE_BLOCK ^ (next_state(opt, st) == 5'h10));
		@(negedge CLK);
	endtask
	task automatic boot(logic act, logic [4:0] st);
		RESET_SEQ = 1'b1;
		@(negedge CLK);
		RESET_SEQ = 1'b0;
		repeat (4) @(negedge CLK);
		chk(BOOT_DONE, 1'b1);
		chk(ACTIVE_BLOCK, act);
		chk(SWAP_STATE, st);
		chk(PHYS_BLOCK, CPU_ADDR[19] ^ act);
		$display("boot test done");
	endtask
	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 2000) begin
			bad_count++;
			report_and_stop();
		end
	end
	initial begin
		repeat (12) @(negedge CLK);
		RST_N = 1'b1;
		@(negedge CLK);
		boot(1'b0, 5'h01);
		chk(SWAP_INITIALISED_FLAG, 1'b0);
		foreach (lfsr[i]) if (i < 6) cmd(i[1:0] ^ 2'h3);
		cmd(2'h0);
		@(negedge CLK);
		chk(SWAP_INITIALISED_FLAG, 1'b1);
		cmd(2'h2);
		boot(1'b1, 5'h02);
		cmd(2'h2);
		cmd(2'h1);
		IND_ERASED = 1'b1;
		@(negedge CLK);
		IND_ERASED = 1'b0;
		chk(SWAP_STATE, 5'h08);
		cmd(2'h2);
		boot(1'b0, 5'h02);
		RST_N = 1'b0;
		@(negedge CLK);
		RST_N = 1'b1;
		@(negedge CLK);
		boot(1'b0, 5'h02);
		report_and_stop();
	end
endmodule
